/* verilog/aps_pkg.sv */
// register map, field positions and reset values of the amplifier bank
package aps_pkg;
  localparam int APS_AW = 7;
  localparam int APS_DW = 8;
  // page holding this bank, page select at offset zero of every page
  localparam logic [7:0] APS_PAGE_AMP = 8'h01;
  localparam logic [6:0] APS_OFS_PAGE = 7'h00;
  localparam logic [6:0] APS_OFS_ERR = 7'h1e;
  localparam logic [6:0] APS_OFS_HP = 7'h1f;
  localparam logic [6:0] APS_OFS_SPK = 7'h20;
  localparam logic [7:0] APS_RST_PAGE = 8'h00;
  // amp_error_control fields
  localparam int APS_ERR_HP_INH = 1;
  localparam int APS_ERR_SPK_INH = 0;
  localparam logic [7:0] APS_RST_ERR = 8'h00;
  // headphone_driver_control fields
  localparam int APS_HP_PWR = 7;
  localparam int APS_HP_CM_HI = 4;
  localparam int APS_HP_CM_LO = 3;
  localparam int APS_HP_RESP = 1;
  localparam int APS_HP_FLAG = 0;
  localparam logic [7:0] APS_HP_RSV_MASK = 8'h64;
  localparam logic [7:0] APS_RST_HP = 8'h04;
  // speaker_amp_control fields
  localparam int APS_SPK_PWR = 7;
  localparam int APS_SPK_FLAG = 0;
  localparam logic [7:0] APS_SPK_RSV_MASK = 8'h7e;
  localparam logic [7:0] APS_RST_SPK = 8'h06;
  // common-mode codes: 1.35 V, 1.5 V, 1.65 V, 1.8 V
  typedef enum logic [1:0] {
    APS_CM_1V35, APS_CM_1V50, APS_CM_1V65, APS_CM_1V80
  } aps_cm_t;
endpackage

/* verilog/aps_amp_regs.sv */
// paged control and status bank for headphone and speaker amplifiers
//
// Operation
// - uninhibited headphone short clears power bit if response bit is one.
// - speaker short clears both half power bits unless inhibit bit set.
// - headphone driver powered while its power bit is one, save during a short with response bit one; resets zero.
// - two-bit field selects headphone common mode 1.35/1.5/1.65/1.8 V.
// - response bit zero makes a headphone short limit load current.
// - response bit one makes a headphone short power the driver down.
// - read-only headphone flag shows live short detection.
// - speaker driver powered while its power bit is one; resets zero.
// - read-only live speaker short flag, meaningful only while powered.
// - page register at offset zero of every page picks the page.
`timescale 1ns/1ps
module aps_amp_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // host control port, paged register access
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [aps_pkg::APS_AW-1:0] addr,
  input wire logic [aps_pkg::APS_DW-1:0] wr_data,
  output logic [aps_pkg::APS_DW-1:0] rd_data,
  // short detectors from the analog drivers, asynchronous
  input wire logic hp_short_det,
  input wire logic spk_short_det,
  // analog controls
  output logic headphone_out_driver_en,
  output logic hp_current_limit,
  output aps_pkg::aps_cm_t hp_common_mode,
  output logic speaker_left_half_pwr,
  output logic speaker_right_half_pwr
);
  import aps_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and write paths
  function automatic logic amp_hit(input logic [7:0] page,
                                   input logic [6:0] a,
                                   input logic [6:0] ofs);
    amp_hit = (page == APS_PAGE_AMP) && (a == ofs);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // detector synchronisers
  logic hp_meta_r, hp_short_r;
  logic spk_meta_r, spk_short_r;

  // two stages each; only the second stage feeds logic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hp_meta_r <= 1'b0;
      hp_short_r <= 1'b0;
      spk_meta_r <= 1'b0;
      spk_short_r <= 1'b0;
    end else begin
      hp_meta_r <= hp_short_det;
      hp_short_r <= hp_meta_r;
      spk_meta_r <= spk_short_det;
      spk_short_r <= spk_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] page_r, page_nxt;
  logic [7:0] err_r, err_nxt;
  logic [7:0] hp_r, hp_nxt;
  logic [7:0] spk_r, spk_nxt;
  logic spk_l_r, spk_l_nxt;
  logic spk_r_r, spk_r_nxt;
  logic wr_page, wr_err, wr_hp, wr_spk;

  assign wr_page = wr_en && (addr == APS_OFS_PAGE);
  assign wr_err = wr_en && amp_hit(page_r, addr, APS_OFS_ERR);
  assign wr_hp = wr_en && amp_hit(page_r, addr, APS_OFS_HP);
  assign wr_spk = wr_en && amp_hit(page_r, addr, APS_OFS_SPK);

  // next register values; a detected short beats a same-cycle write
  always_comb begin
    page_nxt = page_r;
    err_nxt = err_r;
    hp_nxt = hp_r;
    spk_nxt = spk_r;
    spk_l_nxt = spk_l_r;
    spk_r_nxt = spk_r_r;
    if (wr_page) begin
      page_nxt = wr_data;
    end
    if (wr_err) begin
      err_nxt = wr_data;
    end
    if (wr_hp) begin
      hp_nxt = wr_data;
      hp_nxt[APS_HP_FLAG] = 1'b0;
    end
    if (wr_spk) begin
      spk_nxt = wr_data;
      spk_nxt[APS_SPK_FLAG] = 1'b0;
      spk_l_nxt = wr_data[APS_SPK_PWR];
      spk_r_nxt = wr_data[APS_SPK_PWR];
    end
    if (hp_short_r && !err_r[APS_ERR_HP_INH] && hp_r[APS_HP_RESP]) begin
      hp_nxt[APS_HP_PWR] = 1'b0;
    end
    if (spk_short_r && !err_r[APS_ERR_SPK_INH]) begin
      spk_l_nxt = 1'b0;
      spk_r_nxt = 1'b0;
    end
    spk_nxt[APS_SPK_PWR] = spk_l_nxt;
  end

  // register the bank
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      page_r <= APS_RST_PAGE;
      err_r <= APS_RST_ERR;
      hp_r <= APS_RST_HP;
      spk_r <= APS_RST_SPK;
      spk_l_r <= 1'b0;
      spk_r_r <= 1'b0;
    end else begin
      page_r <= page_nxt;
      err_r <= err_nxt;
      hp_r <= hp_nxt;
      spk_r <= spk_nxt;
      spk_l_r <= spk_l_nxt;
      spk_r_r <= spk_r_nxt;
    end
  end

  assign speaker_left_half_pwr = spk_l_r;
  assign speaker_right_half_pwr = spk_r_r;

  //////////////////////////////////////////////////////////////////////////
  // analog control outputs
  logic hp_en_nxt, hp_lim_nxt;
  aps_cm_t cm_nxt;

  // one cycle behind the bank; fine against analog reaction times
  always_comb begin
    hp_en_nxt = hp_r[APS_HP_PWR];
    hp_lim_nxt = 1'b0;
    if (hp_short_r && hp_r[APS_HP_RESP]) begin
      hp_en_nxt = 1'b0;
    end
    if (hp_short_r && !hp_r[APS_HP_RESP] && hp_r[APS_HP_PWR]) begin
      hp_lim_nxt = 1'b1;
    end
    cm_nxt = aps_cm_t'(hp_r[APS_HP_CM_HI:APS_HP_CM_LO]);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      headphone_out_driver_en <= 1'b0;
      hp_current_limit <= 1'b0;
      hp_common_mode <= APS_CM_1V35;
    end else begin
      headphone_out_driver_en <= hp_en_nxt;
      hp_current_limit <= hp_lim_nxt;
      hp_common_mode <= cm_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path; unmapped offsets read zero, data holds between reads
  logic [7:0] rd_nxt;

  always_comb begin
    rd_nxt = rd_data;
    if (rd_en) begin
      rd_nxt = 8'h00;
      if (addr == APS_OFS_PAGE) begin
        rd_nxt = page_r;
      end else if (amp_hit(page_r, addr, APS_OFS_ERR)) begin
        rd_nxt = err_r;
      end else if (amp_hit(page_r, addr, APS_OFS_HP)) begin
        rd_nxt = hp_r;
        rd_nxt[APS_HP_FLAG] = hp_short_r;
      end else if (amp_hit(page_r, addr, APS_OFS_SPK)) begin
        rd_nxt = spk_r;
        rd_nxt[APS_SPK_FLAG] = spk_short_r;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_hp_clear;
    @(posedge mclk) disable iff (!rst_b)
    hp_short_r && !err_r[APS_ERR_HP_INH] && hp_r[APS_HP_RESP]
      |=> !hp_r[APS_HP_PWR] ##1 !headphone_out_driver_en;
  endproperty
  a_hp_clear: assert property (p_hp_clear)
    else $error("headphone power bit not cleared on short");

  property p_spk_clear;
    @(posedge mclk) disable iff (!rst_b)
    spk_short_r && !err_r[APS_ERR_SPK_INH]
      |=> !speaker_left_half_pwr && !speaker_right_half_pwr;
  endproperty
  a_spk_clear: assert property (p_spk_clear)
    else $error("speaker halves not cleared on short");

  property p_spk_keep;
    @(posedge mclk) disable iff (!rst_b)
    spk_short_r && err_r[APS_ERR_SPK_INH] && !wr_spk
      |=> $stable(speaker_left_half_pwr) && $stable(speaker_right_half_pwr);
  endproperty
  a_spk_keep: assert property (p_spk_keep)
    else $error("inhibited speaker power bits changed");

  property p_hp_off;
    @(posedge mclk) disable iff (!rst_b)
    !hp_r[APS_HP_PWR] |=> !headphone_out_driver_en;
  endproperty
  a_hp_off: assert property (p_hp_off)
    else $error("headphone driver on with power bit low");

  property p_cm;
    @(posedge mclk) disable iff (!rst_b)
    wr_hp |=> ##1 hp_common_mode ==
      aps_cm_t'($past(wr_data[APS_HP_CM_HI:APS_HP_CM_LO], 2));
  endproperty
  a_cm: assert property (p_cm)
    else $error("common mode does not follow written field");

  property p_limit;
    @(posedge mclk) disable iff (!rst_b)
    hp_short_r && !hp_r[APS_HP_RESP] && hp_r[APS_HP_PWR]
      |=> hp_current_limit;
  endproperty
  a_limit: assert property (p_limit)
    else $error("current limit not applied on short");

  property p_pdown;
    @(posedge mclk) disable iff (!rst_b)
    hp_short_r && hp_r[APS_HP_RESP] |=> !headphone_out_driver_en;
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("driver not powered down on short");

  property p_hp_flag;
    @(posedge mclk) disable iff (!rst_b)
    rd_en && amp_hit(page_r, addr, APS_OFS_HP)
      |=> rd_data[APS_HP_FLAG] == $past(hp_short_r);
  endproperty
  a_hp_flag: assert property (p_hp_flag)
    else $error("headphone flag reads wrong");

  property p_spk_on;
    @(posedge mclk) disable iff (!rst_b)
    wr_spk && wr_data[APS_SPK_PWR] && !spk_short_r |=> speaker_left_half_pwr;
  endproperty
  a_spk_on: assert property (p_spk_on)
    else $error("speaker not powered after write");

  property p_spk_flag;
    @(posedge mclk) disable iff (!rst_b)
    rd_en && amp_hit(page_r, addr, APS_OFS_SPK)
      |=> rd_data[APS_SPK_FLAG] == $past(spk_short_r);
  endproperty
  a_spk_flag: assert property (p_spk_flag)
    else $error("speaker flag reads wrong");

  property p_page;
    @(posedge mclk) disable iff (!rst_b)
    wr_page ##1 (rd_en && addr == APS_OFS_PAGE && !wr_page)
      |=> rd_data == $past(wr_data, 2);
  endproperty
  a_page: assert property (p_page)
    else $error("page register readback wrong");

  property p_flag_ro;
    @(posedge mclk) disable iff (!rst_b)
    wr_hp || wr_spk |=> !hp_r[APS_HP_FLAG] && !spk_r[APS_SPK_FLAG];
  endproperty
  a_flag_ro: assert property (p_flag_ro)
    else $error("flag bit took written value");
endmodule

/* dv/aps_amp_regs_tb_top.sv */
// self-checking bench for the paged amplifier control and status bank
`timescale 1ns/1ps
module aps_amp_regs_tb_top;
  import aps_pkg::*;

  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_data;
  logic hp_short_det = 1'b0;
  logic spk_short_det = 1'b0;
  logic headphone_out_driver_en;
  logic hp_current_limit;
  aps_cm_t hp_common_mode;
  logic speaker_left_half_pwr;
  logic speaker_right_half_pwr;
  int n_fail = 0;
  int total_checks = 0;

  aps_amp_regs aps_amp_regs_inst (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .hp_short_det(hp_short_det),
    .spk_short_det(spk_short_det),
    .headphone_out_driver_en(headphone_out_driver_en),
    .hp_current_limit(hp_current_limit),
    .hp_common_mode(hp_common_mode),
    .speaker_left_half_pwr(speaker_left_half_pwr),
    .speaker_right_half_pwr(speaker_right_half_pwr)
  );

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////
  // compare, count and report a mismatch at once
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // let n edges pass, then settle just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one-cycle write strobe, inputs moved just after the edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge mclk);
    #1;
    wr_en = 1'b0;
  endtask

  // one-cycle read strobe, data registered at the taking edge
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge mclk);
    #1;
    rd_en = 1'b0;
    chk(rd_data, exp);
  endtask

  // driver outputs packed as one byte: en, limit, left, right
  function automatic logic [7:0] outs();
    return {4'h0, headphone_out_driver_en, hp_current_limit,
            speaker_left_half_pwr, speaker_right_half_pwr};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog: tests need about 120 cycles
  initial begin
    #20000;
    n_fail++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    // reset values and paging
    rd(APS_OFS_PAGE, 8'h00);
    rd(APS_OFS_HP, 8'h00);
    wr(APS_OFS_PAGE, APS_PAGE_AMP);
    rd(APS_OFS_PAGE, 8'h01);
    rd(APS_OFS_ERR, 8'h00);
    rd(APS_OFS_HP, 8'h04);
    rd(APS_OFS_SPK, 8'h06);
    rd(7'h21, 8'h00);
    chk(outs(), 8'h00);
    $display("test reset_and_paging done");
    // every common-mode code; reserved bits kept, flag write dropped
    for (int i = 0; i < 4; i++) begin
      wr(APS_OFS_HP, 8'h85 | {3'h0, i[1:0], 3'h0});
      step(2);
      chk({6'h00, hp_common_mode}, {6'h00, i[1:0]});
      chk(outs(), 8'h08);
      rd(APS_OFS_HP, 8'h84 | {3'h0, i[1:0], 3'h0});
    end
    wr(APS_OFS_SPK, 8'h87);
    chk(outs(), 8'h0b);
    rd(APS_OFS_SPK, 8'h86);
    $display("test power_and_common_mode done");
    // headphone short in current-limit mode keeps power
    wr(APS_OFS_HP, 8'h84);
    hp_short_det = 1'b1;
    step(5);
    chk(outs(), 8'h0f);
    rd(APS_OFS_HP, 8'h85);
    hp_short_det = 1'b0;
    step(4);
    chk(outs(), 8'h0b);
    rd(APS_OFS_HP, 8'h84);
    $display("test hp_limit done");
    // power-down mode with clear inhibited, then inhibit lifted mid-short
    wr(APS_OFS_ERR, 8'h02);
    wr(APS_OFS_HP, 8'h86);
    hp_short_det = 1'b1;
    step(5);
    chk(outs(), 8'h03);
    rd(APS_OFS_HP, 8'h87);
    wr(APS_OFS_ERR, 8'h00);
    step(2);
    rd(APS_OFS_HP, 8'h07);
    hp_short_det = 1'b0;
    step(4);
    chk(outs(), 8'h03);
    rd(APS_OFS_HP, 8'h06);
    $display("test hp_power_down done");
    // speaker short, inhibited then released
    wr(APS_OFS_ERR, 8'h01);
    spk_short_det = 1'b1;
    step(5);
    chk(outs(), 8'h03);
    rd(APS_OFS_SPK, 8'h87);
    wr(APS_OFS_ERR, 8'h00);
    step(2);
    chk(outs(), 8'h00);
    rd(APS_OFS_SPK, 8'h07);
    spk_short_det = 1'b0;
    step(4);
    rd(APS_OFS_SPK, 8'h06);
    $display("test speaker_short done");
    // mid-run reset with both drivers powered brings back reset values
    wr(APS_OFS_HP, 8'h84);
    wr(APS_OFS_SPK, 8'h86);
    step(2);
    chk(outs(), 8'h0b);
    rst_b = 1'b0;
    step(2);
    chk(outs(), 8'h00);
    rst_b = 1'b1;
    rd(APS_OFS_PAGE, 8'h00);
    wr(APS_OFS_PAGE, APS_PAGE_AMP);
    rd(APS_OFS_SPK, 8'h06);
    rd(APS_OFS_HP, 8'h04);
    $display("test mid_reset done");
    conclude();
  end
endmodule
